// ### logic/ssw_supervisor.sv
// Supply supervisor with reset stretcher, watchdog and power-fail output
// Summary of operation
// - Reset on any supply, aux or manual fault
// - Hold reset full timeout after causes clear
// - New undervoltage restarts running timeout
// - Manual reset low asserts reset
// - Hold while manual low, then timeout
// - Debounce manual switch internally, one reset
// - Aux input is third undervoltage cause
// - Output style open-drain or push-pull parameter
// - Active-high reset complements active-low reset
// - Two active-low resets share one state
// - Stuck watchdog input past window resets
// - Long initial window after every reset
// - First edge switches to normal window
// - Missed normal toggle gives timeout reset pulse
// - Power-fail output low when input low
// - Power-fail release unstretched, reset independent
// - Watchdog count clears on reset or edge
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor
   import ssw_pkg::*;
#(
   parameter bit OPEN_DRAIN = 1'b0, // Output style per variant
   parameter longint unsigned RESET_TIMEOUT_CYC = SSW_RESET_TIMEOUT_CYC,
   parameter longint unsigned WD_LONG_CYC = SSW_WD_LONG_CYC,
   parameter longint unsigned WD_NORMAL_CYC = SSW_WD_NORMAL_CYC,
   parameter longint unsigned DEBOUNCE_CYC = SSW_DEBOUNCE_CYC,
   parameter bit WATCHDOG_EN = 1'b1 // Watchdog fitted on this variant
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ssw_fault_type fault_i,       // Comparator fault flags
   input wire logic manual_reset_n_i,       // Manual reset, active low
   input wire logic watchdog_toggle_in_i,   // Processor toggle line
   input wire logic powerfail_below_i,      // Power-fail comparator low
   output ssw_reset_type reset_o,           // Reset output values
   output ssw_reset_type reset_oe_n_o,      // Open-drain enables, low drives
   output logic powerfail_warn_n_o,         // Power-fail warning, active low
   output logic powerfail_warn_oe_n_o       // Its open-drain enable
);

   // Sized count limits
   localparam logic [SSW_CNT_W-1:0] RST_LIM = SSW_CNT_W'(RESET_TIMEOUT_CYC);
   localparam logic [SSW_CNT_W-1:0] LONG_LIM = SSW_CNT_W'(WD_LONG_CYC);
   localparam logic [SSW_CNT_W-1:0] NORM_LIM = SSW_CNT_W'(WD_NORMAL_CYC);
   localparam logic [SSW_CNT_W-1:0] DEB_LIM = SSW_CNT_W'(DEBOUNCE_CYC);
   localparam logic [SSW_CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [SSW_CNT_W-1:0] CNT_ONE = SSW_CNT_W'(1);

   // Saturating increment, used by all counters
   function automatic logic [SSW_CNT_W-1:0] cnt_inc(input logic [SSW_CNT_W-1:0] v);
      cnt_inc = (v == '1) ? v : v + CNT_ONE;
   endfunction : cnt_inc

   // Synchronised inputs
   logic mr_level; // Manual reset after sync
   logic mr_edge;  // Manual reset changed
   logic wd_level; // Watchdog line after sync (unused level)
   logic wd_edge;  // Watchdog line toggled

   // Manual reset synchroniser
   ssw_sync_edge u_sync_mr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(manual_reset_n_i),
      .level_o(mr_level),
      .edge_o(mr_edge)
   );

   // Watchdog synchroniser
   ssw_sync_edge u_sync_wd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(watchdog_toggle_in_i),
      .level_o(wd_level),
      .edge_o(wd_edge)
   );

   // Debounced manual reset state and its settle counter
   logic mr_pressed_q;
   logic [SSW_CNT_W-1:0] deb_cnt_q;

   // Debounce: follow only once the line has been stable for the settle time.
   // A press is seen immediately on the first low; bounce on release is
   // absorbed, so one press gives one stretched reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mr_pressed_q <= 1'b0;
         deb_cnt_q <= CNT_ZERO;
      end else if (mr_edge) begin
         // Any bounce restarts the settle time
         deb_cnt_q <= CNT_ZERO;
         if (!mr_level) begin
            mr_pressed_q <= 1'b1;
         end
      end else if (deb_cnt_q >= DEB_LIM) begin
         // Stable long enough: take the level
         mr_pressed_q <= !mr_level;
      end else begin
         deb_cnt_q <= cnt_inc(deb_cnt_q);
      end
   end

   // Combined undervoltage causes
   logic uv_cause;
   assign uv_cause = fault_i.primary_low | fault_i.secondary_low | fault_i.aux_low;

   // Watchdog state
   ssw_wd_mode_type wd_mode_q;
   logic [SSW_CNT_W-1:0] wd_cnt_q;
   logic wd_expire;
   logic [SSW_CNT_W-1:0] wd_lim;

   // Active window depends on mode
   assign wd_lim = (wd_mode_q == SSW_WD_NORMAL) ? NORM_LIM : LONG_LIM;
   assign wd_expire = WATCHDOG_EN && (wd_cnt_q >= wd_lim);

   // Reset stretcher
   ssw_rs_state_type rs_state_q;
   logic [SSW_CNT_W-1:0] rs_cnt_q;
   logic rst_active; // Internal shared reset state

   assign rst_active = (rs_state_q != SSW_RS_RELEASE);

   // Stretcher: held in ASSERT while any cause is present, then counts
   // the timeout. A watchdog expiry enters the stretch directly, which
   // gives a single timeout-long pulse.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rs_state_q <= SSW_RS_ASSERT;
         rs_cnt_q <= CNT_ZERO;
      end else begin
         unique case (rs_state_q)
            SSW_RS_ASSERT: begin
               rs_cnt_q <= CNT_ZERO;
               if (!uv_cause && !mr_pressed_q) begin
                  rs_state_q <= SSW_RS_STRETCH;
               end
            end
            SSW_RS_STRETCH: begin
               if (uv_cause || mr_pressed_q) begin
                  // Drop during timeout: back to assert, count restarts
                  rs_state_q <= SSW_RS_ASSERT;
                  rs_cnt_q <= CNT_ZERO;
               end else if (rs_cnt_q >= RST_LIM - CNT_ONE) begin
                  rs_state_q <= SSW_RS_RELEASE;
               end else begin
                  rs_cnt_q <= cnt_inc(rs_cnt_q);
               end
            end
            SSW_RS_RELEASE: begin
               rs_cnt_q <= CNT_ZERO;
               if (uv_cause || mr_pressed_q) begin
                  rs_state_q <= SSW_RS_ASSERT;
               end else if (wd_expire) begin
                  rs_state_q <= SSW_RS_STRETCH;
               end
            end
         endcase
      end
   end

   // Watchdog counter and mode. Any reset returns to the long window;
   // the first edge outside reset switches to the normal window.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_mode_q <= SSW_WD_LONG;
         wd_cnt_q <= CNT_ZERO;
      end else if (rst_active) begin
         wd_mode_q <= SSW_WD_LONG;
         wd_cnt_q <= CNT_ZERO;
      end else if (wd_edge) begin
         wd_mode_q <= SSW_WD_NORMAL;
         wd_cnt_q <= CNT_ZERO;
      end else begin
         wd_cnt_q <= cnt_inc(wd_cnt_q);
      end
   end

   // Output registers
   ssw_reset_type reset_q;
   ssw_reset_type reset_oe_n_q;
   logic pf_q;
   logic pf_oe_n_q;

   // Reset outputs: all three come from the same registered state value, so
   // they never disagree, even for a cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_q <= ssw_reset_type'(3'b001);
         // Low levels always driven; the high level only when push-pull
         reset_oe_n_q.first_reset_out_n <= 1'b0;
         reset_oe_n_q.second_reset_out_n <= 1'b0;
         reset_oe_n_q.reset_out_h <= OPEN_DRAIN;
      end else begin
         reset_q.first_reset_out_n <= !rst_active;
         reset_q.second_reset_out_n <= !rst_active;
         reset_q.reset_out_h <= rst_active;
         // Open-drain drives only the low level; push-pull always drives
         reset_oe_n_q.first_reset_out_n <= OPEN_DRAIN && !rst_active;
         reset_oe_n_q.second_reset_out_n <= OPEN_DRAIN && !rst_active;
         reset_oe_n_q.reset_out_h <= OPEN_DRAIN && rst_active;
      end
   end

   // Power-fail output follows the comparator, no stretch, no reset link
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pf_q <= 1'b1;
         pf_oe_n_q <= 1'b0;
      end else begin
         pf_q <= !powerfail_below_i;
         pf_oe_n_q <= OPEN_DRAIN && !powerfail_below_i;
      end
   end

   assign reset_o = reset_q;
   assign reset_oe_n_o = reset_oe_n_q;
   assign powerfail_warn_n_o = pf_q;
   assign powerfail_warn_oe_n_o = pf_oe_n_q;

   // Level of the watchdog line is not needed beyond its edges
   logic wd_level_unused;
   assign wd_level_unused = wd_level;

endmodule : ssw_supervisor
`default_nettype wire

// ### logic/ssw_pkg.sv
// Package for the supply supervisor and watchdog block
package ssw_pkg;

   // Clock rate of clk_i in hertz (250 MHz)
   localparam longint unsigned SSW_CLK_HZ = 64'd250_000_000;

   // Reset timeout period in microseconds (plain default)
   localparam longint unsigned SSW_RESET_TIMEOUT_US = 64'd200_000;
   // Long initial watchdog window in milliseconds
   localparam longint unsigned SSW_WD_LONG_MS = 64'd35_000;
   // Normal watchdog window in milliseconds
   localparam longint unsigned SSW_WD_NORMAL_MS = 64'd1_120;
   // Manual reset debounce settle time in microseconds
   localparam longint unsigned SSW_DEBOUNCE_US = 64'd1_000;

   // Cycle counts derived from the times (least times round up)
   localparam longint unsigned SSW_RESET_TIMEOUT_CYC =
      (SSW_RESET_TIMEOUT_US * SSW_CLK_HZ + 64'd999_999) / 64'd1_000_000;
   localparam longint unsigned SSW_WD_LONG_CYC =
      (SSW_WD_LONG_MS * SSW_CLK_HZ + 64'd999) / 64'd1_000;
   localparam longint unsigned SSW_WD_NORMAL_CYC =
      (SSW_WD_NORMAL_MS * SSW_CLK_HZ + 64'd999) / 64'd1_000;
   localparam longint unsigned SSW_DEBOUNCE_CYC =
      (SSW_DEBOUNCE_US * SSW_CLK_HZ + 64'd999_999) / 64'd1_000_000;

   // Counter width; the long window at 250 MHz needs 34 bits, ten spare
   localparam int SSW_CNT_W = 44;

   // Synchroniser reset value of the inputs (idle levels)
   localparam logic SSW_SYNC_RST_VAL = 1'b1;

   // Raw fault indications from the comparators and pins
   typedef struct packed {
      logic primary_low;   // Primary supply below threshold
      logic secondary_low; // Secondary supply below threshold
      logic aux_low;       // Auxiliary monitor below reference
   } ssw_fault_type;

   // Reset output group
   typedef struct packed {
      logic first_reset_out_n;  // Active-low reset
      logic second_reset_out_n; // Second active-low reset
      logic reset_out_h;        // Active-high reset
   } ssw_reset_type;

   // Watchdog modes
   typedef enum logic {
      SSW_WD_LONG,
      SSW_WD_NORMAL
   } ssw_wd_mode_type;

   // Reset stretcher states
   typedef enum logic [1:0] {
      SSW_RS_ASSERT,
      SSW_RS_STRETCH,
      SSW_RS_RELEASE
   } ssw_rs_state_type;

endpackage : ssw_pkg

// ### logic/ssw_sync_edge.sv
// Two-stage synchroniser with edge detector for one input
`timescale 1ns/1ps
`default_nettype none
module ssw_sync_edge
   import ssw_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic level_o,
   output logic edge_o
);

   logic meta_q; // First stage, read only by the second stage
   logic sync_q; // Second stage
   logic last_q; // Previous synced value for edge detect

   // Synchroniser chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= SSW_SYNC_RST_VAL;
         sync_q <= SSW_SYNC_RST_VAL;
         last_q <= SSW_SYNC_RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Level and either-direction edge
   assign level_o = sync_q;
   assign edge_o = sync_q ^ last_q;

endmodule : ssw_sync_edge
`default_nettype wire

// ### tb/ssw_checker.sv
// Checker for the supervisor reset, watchdog and power-fail outputs
`timescale 1ns/1ps
`default_nettype none
module ssw_checker
   import ssw_pkg::*;
#(
   parameter longint unsigned RESET_TIMEOUT_CYC = 20,
   parameter longint unsigned WD_LONG_CYC = 200,
   parameter longint unsigned WD_NORMAL_CYC = 50
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ssw_fault_type fault_i,
   input wire logic manual_reset_n_i,
   input wire logic watchdog_toggle_in_i,
   input wire logic powerfail_below_i,
   input wire ssw_reset_type reset_o,
   input wire ssw_reset_type reset_oe_n_o,
   input wire logic powerfail_warn_n_o,
   input wire logic powerfail_warn_oe_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rel; // Reset outputs released
   longint unsigned quiet_q; // Cycles without any cause
   longint unsigned wd_q; // Idle cycles of the toggle line
   logic seen_q; // Toggle seen since release
   assign rel = reset_o.first_reset_out_n;
   // Any cause restarts the quiet count
   always_ff @(posedge clk_i) begin
      if (rst_i || (|fault_i) || !manual_reset_n_i) begin
         quiet_q <= '0;
      end else begin
         quiet_q <= quiet_q + 64'h1;
      end
   end
   // Idle count cleared by reset or a toggle, as the watchdog does
   always_ff @(posedge clk_i) begin
      if (rst_i || !rel || $changed(watchdog_toggle_in_i)) begin
         wd_q <= '0;
      end else begin
         wd_q <= wd_q + 64'h1;
      end
   end
   // First toggle after release selects the short window
   always_ff @(posedge clk_i) begin
      if (rst_i || !rel) begin
         seen_q <= 1'b0;
      end else if ($changed(watchdog_toggle_in_i)) begin
         seen_q <= 1'b1;
      end
   end
   property p_fault; |fault_i |-> ##2 !reset_o.first_reset_out_n; endproperty
   a_fault: assert property (p_fault) else $error("fault did not assert reset");
   property p_comp; reset_o.reset_out_h == !reset_o.first_reset_out_n; endproperty
   a_comp: assert property (p_comp) else $error("high reset not complement");
   property p_same; reset_o.second_reset_out_n == rel; endproperty
   a_same: assert property (p_same) else $error("two resets differ");
   property p_oe; reset_oe_n_o == '0; endproperty
   a_oe: assert property (p_oe) else $error("push-pull reset not driven");
   property p_pf; !$past(rst_i) |-> powerfail_warn_n_o == !$past(powerfail_below_i); endproperty
   a_pf: assert property (p_pf) else $error("power-fail output wrong");
   property p_mr; !manual_reset_n_i [*6] |-> !rel; endproperty
   a_mr: assert property (p_mr) else $error("manual press ignored");
   property p_hold; $rose(rel) |-> quiet_q >= RESET_TIMEOUT_CYC; endproperty
   a_hold: assert property (p_hold) else $error("reset released early");
   property p_wd; rel |-> wd_q <= WD_LONG_CYC + 6; endproperty
   a_wd: assert property (p_wd) else $error("long window overrun");
   property p_norm; seen_q && rel |-> wd_q <= WD_NORMAL_CYC + 6; endproperty
   a_norm: assert property (p_norm) else $error("normal window overrun");
endmodule : ssw_checker
bind ssw_supervisor ssw_checker #(.RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC),
   .WD_LONG_CYC(WD_LONG_CYC), .WD_NORMAL_CYC(WD_NORMAL_CYC)) i_ssw_checker (
   .clk_i(clk_i), .rst_i(rst_i), .fault_i(fault_i), .manual_reset_n_i(manual_reset_n_i),
   .watchdog_toggle_in_i(watchdog_toggle_in_i), .powerfail_below_i(powerfail_below_i),
   .reset_o(reset_o), .reset_oe_n_o(reset_oe_n_o), .powerfail_warn_n_o(powerfail_warn_n_o),
   .powerfail_warn_oe_n_o(powerfail_warn_oe_n_o));
`default_nettype wire

// ### tb/ssw_cpu_model.sv
// Processor model that toggles the watchdog line while out of reset
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model #(
   parameter int GAP = 30
)
(
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic run_i,
   output logic toggle_o
);
   int cnt; // Cycles since the last toggle
   initial begin
      toggle_o = 1'b0;
      cnt = 0;
   end
   // A processor in reset or hung leaves the line still
   always @(posedge clk_i) begin
      if (!en_i || run_i !== 1'b1) begin
         cnt <= 0;
      end else if (cnt == GAP - 1) begin
         cnt <= 0;
         toggle_o <= ~toggle_o;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : ssw_cpu_model
`default_nettype wire

// ### tb/tb.sv
// Testbench for the supply supervisor and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb
   import ssw_pkg::*;
;
   localparam int RTC = 20; // Short reset timeout
   localparam int LWC = 200; // Short long window
   localparam int NWC = 50; // Short normal window
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   ssw_fault_type fault_i = '0;
   logic mr_n = 1'b1; // Manual reset line
   logic pf_below = 1'b0;
   logic wd_en = 1'b1; // Processor keeps toggling
   logic wdt;
   ssw_reset_type rst_v;
   ssw_reset_type rst_oe;
   logic pf_n;
   logic pf_oe; // Power-fail output enable
   int miscompares = 0;
   int n_tests = 0;
   logic [31:0] rng = 32'h0000_0042;
   int n;
   int k;
   always #2 clk_i = ~clk_i;
   ssw_supervisor #(.RESET_TIMEOUT_CYC(RTC), .WD_LONG_CYC(LWC), .WD_NORMAL_CYC(NWC),
      .DEBOUNCE_CYC(4)) i_ssw_supervisor (.clk_i(clk_i), .rst_i(rst_i), .fault_i(fault_i),
      .manual_reset_n_i(mr_n), .watchdog_toggle_in_i(wdt), .powerfail_below_i(pf_below),
      .reset_o(rst_v), .reset_oe_n_o(rst_oe), .powerfail_warn_n_o(pf_n),
      .powerfail_warn_oe_n_o(pf_oe));
   ssw_cpu_model #(.GAP(30)) i_ssw_cpu_model (.clk_i(clk_i), .en_i(wd_en),
      .run_i(rst_v.first_reset_out_n), .toggle_o(wdt));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Expected latency window
   function automatic logic in_win(input int v, input int lo, input int hi);
      return (v >= lo && v <= hi);
   endfunction : in_win
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   // Bounded waits for release and for assertion
   task automatic wait_rel(output int c);
      c = 0;
      while (rst_v.first_reset_out_n !== 1'b1 && c < 2000) begin
         @(negedge clk_i);
         c++;
      end
   endtask : wait_rel
   task automatic wait_asrt(output int c);
      c = 0;
      while (rst_v.first_reset_out_n === 1'b1 && c < 2000) begin
         @(negedge clk_i);
         c++;
      end
   endtask : wait_asrt
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_rel(n);
      chk("por", in_win(n, RTC, RTC + 6), 1'b1);
      chk("oe", rst_oe, '0);
      $display("done power-on");
      // Random faults, re-fault mid-stretch, power-fail alongside
      for (int i = 0; i < 6; i++) begin
         rng = xs(rng);
         @(posedge clk_i);
         fault_i <= (rng[2:0] == 3'h0) ? 3'h4 : rng[2:0];
         pf_below <= rng[3];
         repeat (2) @(posedge clk_i);
         @(negedge clk_i);
         chk("fault", rst_v, 8'h01);
         chk("pf", pf_n, !pf_below);
         chk("pf_oe", pf_oe, 1'b0);
         repeat (rng[6:4]) @(posedge clk_i);
         fault_i <= '0;
         repeat (rng[10:8] + 4) @(posedge clk_i);
         fault_i <= 3'h1;
         pf_below <= rng[11];
         @(posedge clk_i);
         fault_i <= '0;
         wait_rel(n);
         chk("restart", in_win(n, RTC, RTC + 6), 1'b1);
         chk("pf_rel", pf_n, !pf_below);
      end
      $display("done faults");
      // Bouncing press, held low, bouncing release
      for (int b = 0; b < 16; b++) begin
         @(posedge clk_i);
         mr_n <= (b < 4 || b > 11) ? b[0] : 1'b0;
      end
      chk("mr_low", rst_v.first_reset_out_n, 1'b0);
      wait_rel(n);
      chk("mr_rel", in_win(n, RTC, RTC + 12), 1'b1);
      k = 0;
      repeat (40) begin
         @(negedge clk_i);
         k += (rst_v.first_reset_out_n !== 1'b1);
      end
      chk("mr_once", k, 0);
      $display("done manual");
      // Processor stops toggling in normal mode, then stays hung
      @(wdt);
      wd_en <= 1'b0;
      wait_asrt(n);
      chk("wd_norm", in_win(n, NWC, NWC + 8), 1'b1);
      wait_rel(n);
      chk("wd_pulse", in_win(n, RTC, RTC + 6), 1'b1);
      wait_asrt(n);
      chk("wd_long", in_win(n, LWC, LWC + 8), 1'b1);
      $display("done watchdog");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
